// file: hw/eisa_defs.vh
// Constants for the two-wire memory target front end
`ifndef EISA_DEFS_VH
`define EISA_DEFS_VH
// Select byte layout and type identifiers
`define EISA_TYPE_MEM 4'ha
`define EISA_TYPE_IDP 4'hb
`define EISA_SEL_TYPE_HI 7
`define EISA_SEL_TYPE_LO 4
`define EISA_SEL_CE 3
`define EISA_SEL_A9 2
`define EISA_SEL_A8 1
`define EISA_SEL_RW 0
// Address byte fields
`define EISA_ADR_LOCK 7
`define EISA_ADR_PAGE_HI 3
// Bit slot counts within one byte frame
`define EISA_BITS_DATA 4'h8
`define EISA_BITS_ACK 4'h9
`define EISA_BITS_ZERO 4'h0
`define EISA_BITS_ONE 4'h1
// Protocol phases
`define EISA_PH_IDLE 3'h0
`define EISA_PH_SEL 3'h1
`define EISA_PH_ADDR 3'h2
`define EISA_PH_DATA 3'h3
`define EISA_PH_BUSY 3'h4
// Reset values and page address step
`define EISA_BYTE_RST 8'h00
`define EISA_ADDR_RST 10'h000
`define EISA_PAGE_STEP 4'h1
`endif

// file: hw/eisa_target.v
// Two-wire serial memory target: start/stop, select decode, address, data acknowledge
`timescale 1ns/1ns
`include "eisa_defs.vh"
// Functional notes
// - Start is SDA fall with SCL high
// - Watch for Start always, except write cycle
// - Stop is SDA rise with SCL high
// - Stop after write launches write cycle
// - Sample SDA on SCL rising edge
// - Receiver pulls SDA low on ninth pulse
// - Acknowledge only type 1010b or 1011b
// - Respond only when b3 matches strap
// - Floating strap reads as zero
// - Select bit 0: one read, zero write
// - Select byte arrives MSB first
// - b2 b1 give address bits 9 and 8
// - ID page ignores b2 b1, low nibble
// - No match: release bus, standby until Start
// - Match: acknowledge; on write expect address byte, on read signal request and go idle
// - Acknowledge the address byte
// - Write protect high blocks array writes
// - Write protect high: no data acknowledge
// - Array is 64 pages of 16 bytes
// - SDA open drain, pull low only
// - Always target, never drives the clock
// - Write only on Stop in tenth slot
// - Busy: SDA released, no answers
// - ID page write uses address bit 7 zero
// - ID lock uses address bit 7 one
module eisa_target #(
  parameter WR_CYCLES = 20000,
  parameter CNT_W = 16
) (
  input wire clk_sys,
  input wire resetn,
  input wire scl_in,
  input wire sda_in,
  output reg sda_out_q,
  output reg sda_oe_n_q,
  input wire chip_select_strap,
  input wire write_protect_input,
  output reg [9:0] mem_addr_q,
  output reg id_page_q,
  output reg id_lock_q,
  output reg [7:0] wr_data_q,
  output reg wr_strobe_q,
  output reg rd_start_q,
  output reg wcyc_start_q,
  output reg busy_q
);

  localparam [CNT_W-1:0] WR_LAST = WR_CYCLES - 1;

  reg scl_s1_q, scl_s2_q, scl_s3_q;
  reg sda_s1_q, sda_s2_q, sda_s3_q;
  reg ce_s1_q, ce_s2_q;
  reg wp_s1_q, wp_s2_q;
  reg [2:0] phase_q;
  reg [3:0] bit_cnt_q;
  reg [7:0] shift_q;
  reg ack_q;
  reg any_q;
  reg rw_q;
  reg [CNT_W-1:0] wr_cnt_q;

  wire scl_rise;
  wire scl_fall;
  wire start_seen;
  wire stop_seen;
  wire receiving;

  // Type identifier and chip-enable bit must both match
  function sel_match;
    input [7:0] sel;
    input ce;
    begin
      sel_match = ((sel[`EISA_SEL_TYPE_HI:`EISA_SEL_TYPE_LO] == `EISA_TYPE_MEM) ||
                   (sel[`EISA_SEL_TYPE_HI:`EISA_SEL_TYPE_LO] == `EISA_TYPE_IDP)) &&
                  (sel[`EISA_SEL_CE] == ce);
    end
  endfunction

  // Only stage two and three feed the edge logic; stage one is metastability margin
  always @(posedge clk_sys) begin
    if (!resetn) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_s3_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_s3_q <= 1'b1;
      ce_s1_q <= 1'b0;
      ce_s2_q <= 1'b0;
      wp_s1_q <= 1'b0;
      wp_s2_q <= 1'b0;
    end else begin
      scl_s1_q <= scl_in;
      scl_s2_q <= scl_s1_q;
      scl_s3_q <= scl_s2_q;
      sda_s1_q <= sda_in;
      sda_s2_q <= sda_s1_q;
      sda_s3_q <= sda_s2_q;
      ce_s1_q <= chip_select_strap;
      ce_s2_q <= ce_s1_q;
      wp_s1_q <= write_protect_input;
      wp_s2_q <= wp_s1_q;
    end
  end

  assign scl_rise = scl_s2_q && !scl_s3_q;
  assign scl_fall = !scl_s2_q && scl_s3_q;
  assign start_seen = scl_s2_q && scl_s3_q && sda_s3_q && !sda_s2_q;
  assign stop_seen = scl_s2_q && scl_s3_q && !sda_s3_q && sda_s2_q;
  assign receiving = (phase_q == `EISA_PH_SEL) || (phase_q == `EISA_PH_ADDR) ||
                     (phase_q == `EISA_PH_DATA);

  always @(posedge clk_sys) begin
    if (!resetn) begin
      phase_q <= `EISA_PH_IDLE;
      bit_cnt_q <= `EISA_BITS_ZERO;
      shift_q <= `EISA_BYTE_RST;
      ack_q <= 1'b0;
      any_q <= 1'b0;
      rw_q <= 1'b0;
      wr_cnt_q <= {CNT_W{1'b0}};
      sda_out_q <= 1'b0;
      sda_oe_n_q <= 1'b1;
      mem_addr_q <= `EISA_ADDR_RST;
      id_page_q <= 1'b0;
      id_lock_q <= 1'b0;
      wr_data_q <= `EISA_BYTE_RST;
      wr_strobe_q <= 1'b0;
      rd_start_q <= 1'b0;
      wcyc_start_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      // Data pin only ever pulls low; the high level comes from the pull-up
      sda_out_q <= 1'b0;
      wr_strobe_q <= 1'b0;
      rd_start_q <= 1'b0;
      wcyc_start_q <= 1'b0;
      if (phase_q == `EISA_PH_BUSY) begin
        // Bus is ignored entirely until the write cycle has run out
        sda_oe_n_q <= 1'b1;
        if (wr_cnt_q == WR_LAST) begin
          wr_cnt_q <= {CNT_W{1'b0}};
          phase_q <= `EISA_PH_IDLE;
          busy_q <= 1'b0;
        end else begin
          wr_cnt_q <= wr_cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end else if (start_seen) begin
        phase_q <= `EISA_PH_SEL;
        bit_cnt_q <= `EISA_BITS_ZERO;
        sda_oe_n_q <= 1'b1;
        ack_q <= 1'b0;
        any_q <= 1'b0;
      end else if (stop_seen) begin
        sda_oe_n_q <= 1'b1;
        bit_cnt_q <= `EISA_BITS_ZERO;
        // The Stop's own SCL rise is the tenth slot; it has already bumped the count to one
        if ((phase_q == `EISA_PH_DATA) && (bit_cnt_q == `EISA_BITS_ONE) && any_q) begin
          phase_q <= `EISA_PH_BUSY;
          wcyc_start_q <= 1'b1;
          busy_q <= 1'b1;
        end else begin
          phase_q <= `EISA_PH_IDLE;
        end
        any_q <= 1'b0;
      end else if (receiving && scl_rise) begin
        // Sampling on the rising edge relies on the master holding SDA across it
        if (bit_cnt_q < `EISA_BITS_DATA) begin
          shift_q <= {shift_q[6:0], sda_s2_q};
          bit_cnt_q <= bit_cnt_q + `EISA_BITS_ONE;
        end else if (bit_cnt_q == `EISA_BITS_DATA) begin
          bit_cnt_q <= `EISA_BITS_ACK;
        end
      end else if (receiving && scl_fall) begin
        if (bit_cnt_q == `EISA_BITS_DATA) begin
          // Ninth slot opens: decide acknowledge and latch the byte's meaning
          case (phase_q)
            `EISA_PH_SEL: begin
              ack_q <= sel_match(shift_q, ce_s2_q);
              sda_oe_n_q <= !sel_match(shift_q, ce_s2_q);
              rw_q <= shift_q[`EISA_SEL_RW];
              if (sel_match(shift_q, ce_s2_q)) begin
                id_page_q <= (shift_q[`EISA_SEL_TYPE_HI:`EISA_SEL_TYPE_LO] ==
                              `EISA_TYPE_IDP);
                if (shift_q[`EISA_SEL_TYPE_HI:`EISA_SEL_TYPE_LO] == `EISA_TYPE_MEM) begin
                  mem_addr_q[9] <= shift_q[`EISA_SEL_A9];
                  mem_addr_q[8] <= shift_q[`EISA_SEL_A8];
                end
              end
            end
            `EISA_PH_ADDR: begin
              ack_q <= 1'b1;
              sda_oe_n_q <= 1'b0;
              if (id_page_q) begin
                // Page write needs bit 7 clear, lock needs it set
                mem_addr_q <= {6'h00, shift_q[`EISA_ADR_PAGE_HI:0]};
                id_lock_q <= shift_q[`EISA_ADR_LOCK];
              end else begin
                mem_addr_q[7:0] <= shift_q;
                id_lock_q <= 1'b0;
              end
            end
            `EISA_PH_DATA: begin
              ack_q <= !wp_s2_q;
              sda_oe_n_q <= wp_s2_q;
              if (!wp_s2_q) begin
                wr_data_q <= shift_q;
                wr_strobe_q <= 1'b1;
              end
            end
            default: begin
              ack_q <= 1'b0;
              sda_oe_n_q <= 1'b1;
            end
          endcase
        end else if (bit_cnt_q == `EISA_BITS_ACK) begin
          sda_oe_n_q <= 1'b1;
          bit_cnt_q <= `EISA_BITS_ZERO;
          case (phase_q)
            `EISA_PH_SEL: begin
              if (!ack_q) begin
                phase_q <= `EISA_PH_IDLE;
              end else if (rw_q) begin
                // Data output is handled elsewhere; this front end only frames the request
                phase_q <= `EISA_PH_IDLE;
                rd_start_q <= 1'b1;
              end else begin
                phase_q <= `EISA_PH_ADDR;
              end
            end
            `EISA_PH_ADDR: begin
              phase_q <= `EISA_PH_DATA;
            end
            `EISA_PH_DATA: begin
              if (ack_q) begin
                any_q <= 1'b1;
                // Page roll-over: only the byte-in-page bits advance
                mem_addr_q[3:0] <= mem_addr_q[3:0] + `EISA_PAGE_STEP;
              end
            end
            default: begin
              phase_q <= `EISA_PH_IDLE;
            end
          endcase
        end
      end
    end
  end

  // The block never drives SCL: it has no clock output at all

endmodule

// file: verif/eisa_master.sv
// Two-wire bus master model driving the link pins
`timescale 1ns/1ns
module eisa_master (
  input wire clk,
  input wire sda_w,
  output logic scl = 1'b1,
  output logic sda = 1'b1
);
  task w(input int n);
    repeat (n) @(posedge clk);
  endtask
  task start;
    sda <= 1'b1;
    w(2);
    scl <= 1'b1;
    w(4);
    sda <= 1'b0;
    w(4);
    scl <= 1'b0;
    w(1);
  endtask
  task stop;
    sda <= 1'b0;
    w(3);
    scl <= 1'b1;
    w(4);
    sda <= 1'b1;
    w(4);
  endtask
  // Data moves one cycle after the clock falls, never while it is high
  task bt(input logic b, output logic r);
    sda <= b;
    w(3);
    scl <= 1'b1;
    w(2);
    r = sda_w;
    w(2);
    scl <= 1'b0;
    w(1);
  endtask
  task tx(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bt(d[i], r);
    bt(1'b1, r);
    ack = !r;
  endtask
endmodule

// file: verif/eisa_target_assertions.sv
// Concurrent checks on the two-wire memory target ports
`timescale 1ns/1ns
module eisa_chk #(
  parameter WR_CYCLES = 20000
) (
  input wire clk_sys,
  input wire resetn,
  input wire scl_in,
  input wire sda_in,
  input wire sda_out_q,
  input wire sda_oe_n_q,
  input wire chip_select_strap,
  input wire write_protect_input,
  input wire [9:0] mem_addr_q,
  input wire id_page_q,
  input wire id_lock_q,
  input wire [7:0] wr_data_q,
  input wire wr_strobe_q,
  input wire rd_start_q,
  input wire wcyc_start_q,
  input wire busy_q
);
  int cnt_q;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  always @(posedge clk_sys) begin
    if (!resetn || !busy_q) cnt_q <= 0;
    else cnt_q <= cnt_q + 1;
  end
  sda_low_a: assert property (sda_out_q == 1'b0)
    else $error("data pin driven high");
  busy_rel_a: assert property (busy_q |-> sda_oe_n_q)
    else $error("pin pulled while busy");
  wcyc_busy_a: assert property (wcyc_start_q |-> busy_q)
    else $error("write launch without busy");
  strb_ack_a: assert property (wr_strobe_q |-> ##[0:2] !sda_oe_n_q)
    else $error("data byte not acknowledged");
  strb_pulse_a: assert property (wr_strobe_q |=> !wr_strobe_q)
    else $error("strobe longer than one cycle");
  wp_strb_a: assert property (wr_strobe_q |-> !write_protect_input)
    else $error("write while protected");
  busy_len_a: assert property ($fell(busy_q) && $past(resetn) |->
    cnt_q >= WR_CYCLES - 1 && cnt_q <= WR_CYCLES + 1)
    else $error("write cycle length wrong");
  wcyc_stop_a: assert property (wcyc_start_q |-> scl_in && sda_in)
    else $error("write launched without stop");
  ack_len_a: assert property ($fell(sda_oe_n_q) |-> !sda_oe_n_q[*6])
    else $error("acknowledge too short");
  cover property (wr_strobe_q);
  cover property (wcyc_start_q);
  cover property (rd_start_q);
endmodule
bind eisa_target eisa_chk #(.WR_CYCLES(WR_CYCLES)) u_chk (
  .clk_sys(clk_sys), .resetn(resetn), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out_q(sda_out_q), .sda_oe_n_q(sda_oe_n_q), .chip_select_strap(chip_select_strap),
  .write_protect_input(write_protect_input), .mem_addr_q(mem_addr_q),
  .id_page_q(id_page_q), .id_lock_q(id_lock_q), .wr_data_q(wr_data_q),
  .wr_strobe_q(wr_strobe_q), .rd_start_q(rd_start_q),
  .wcyc_start_q(wcyc_start_q), .busy_q(busy_q)
);

// file: verif/tb_top.sv
// Self-checking bench for the two-wire memory target
`timescale 1ns/1ns
module tb_top;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic strap = 1'b0;
  logic wp = 1'b0;
  logic ack;
  wire scl_in, sda_m, sda_oe_n_q, id_page_q, id_lock_q, busy_q;
  wire [9:0] mem_addr_q;
  wire [7:0] wr_data_q;
  int failures = 0;
  int n_tests = 0;
  int cyc = 0;
  initial forever #25 clk_sys = ~clk_sys;
  // Open-drain net with pull-up
  wire sda_in = sda_m & sda_oe_n_q;
  eisa_master m (.clk(clk_sys), .sda_w(sda_in), .scl(scl_in), .sda(sda_m));
  eisa_target #(.WR_CYCLES(200)) dut (.clk_sys, .resetn, .scl_in, .sda_in,
    .sda_out_q(), .sda_oe_n_q, .chip_select_strap(strap), .write_protect_input(wp),
    .mem_addr_q, .id_page_q, .id_lock_q, .wr_data_q, .wr_strobe_q(),
    .rd_start_q(), .wcyc_start_q(), .busy_q);
  task chk(input logic [15:0] s, e);
    n_tests++;
    if (s !== e) begin
      failures++;
      $display("BAD t=%0t got %h exp %h", $time, s, e);
    end
  endtask
  task sel(input logic [7:0] d, input logic e);
    m.start;
    m.tx(d, ack);
    chk(ack, e);
  endtask
  task t_types;
    for (int t = 0; t < 16; t++) begin
      sel({t[3:0], 4'h0}, t == 10 || t == 11);
      m.stop;
    end
    sel(8'ha8, 1'b0);
    m.tx(8'h00, ack);
    chk(ack, 1'b0);
    m.stop;
    strap <= 1'b1;
    sel(8'hb8, 1'b1);
    m.stop;
    strap <= 1'b0;
    sel(8'ha1, 1'b1);
    m.stop;
  endtask
  task t_write;
    sel(8'ha4, 1'b1);
    m.tx(8'h5f, ack);
    chk(ack, 1'b1);
    chk(mem_addr_q, 10'h25f);
    m.tx(8'h3c, ack);
    chk(ack, 1'b1);
    chk(wr_data_q, 8'h3c);
    m.w(4);
    chk(mem_addr_q, 10'h250);
    m.stop;
    chk(busy_q, 1'b1);
    sel(8'ha4, 1'b0);
    m.stop;
    m.w(200);
    sel(8'ha4, 1'b1);
    m.stop;
    chk(busy_q, 1'b0);
  endtask
  task t_wp;
    wp <= 1'b1;
    sel(8'ha0, 1'b1);
    m.tx(8'h10, ack);
    chk(ack, 1'b1);
    m.tx(8'h77, ack);
    chk(ack, 1'b0);
    m.stop;
    chk(busy_q, 1'b0);
    wp <= 1'b0;
  endtask
  task t_idp;
    sel(8'hb6, 1'b1);
    m.tx(8'h85, ack);
    chk({id_page_q, id_lock_q, mem_addr_q}, 12'hc05);
    m.bt(1'b1, ack);
    sel(8'ha2, 1'b1);
    m.tx(8'h05, ack);
    chk({id_page_q, mem_addr_q}, 11'h105);
    m.stop;
    chk(busy_q, 1'b0);
  endtask
  task stop_test;
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    m.w(20);
    resetn <= 1'b1;
    m.w(5);
    t_types;
    t_write;
    t_wp;
    t_idp;
    stop_test;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 10000) begin
      failures++;
      stop_test;
    end
  end
endmodule
